// ---- design/ooc_pkg.sv ----
// Notes on behaviour
// - Operation byte sets state with enable pin.
// - Bits 7:6 = 00: output off at once.
// - Bits 7:6 = 01: off via delay and fall.
// - Bits 5:4 pick nominal, margin low, high.
// - Bits 3:2 ignore or act on margin faults.
// - Eight illegal bit 7:2 patterns set fault flag.
// - Any other operation byte is applied.
// - Store-all copies both control bytes.
// - Config bit 4 low: on with bias.
// - Config bit 3 high: operation bit 7 needed.
// - Config bit 2 high: enable pin needed.
// - Config bit 1: only active-high pin supported.
// - Config bit 0 picks pin shutdown mode.
// - Valid modes 0XX1, 1011, 1101, 1111.
// - Config byte resets to 0x17.
// - Bad data discarded, CML flags set.
package ooc_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] OOC_CMD_OPERATION = 8'h01;
  localparam logic [7:0] OOC_CMD_CONFIG = 8'h02;
  localparam logic [7:0] OOC_CMD_STORE_ALL = 8'h15;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] OOC_OPERATION_RESET = 8'h00;
  localparam logic [7:0] OOC_CONFIG_RESET = 8'h17;
  localparam logic [7:0] OOC_BYTE_ZERO = 8'h00;

  // ==========================================================================
  // Operation byte fields
  localparam int OOC_OP_ON_BIT = 7;
  localparam int OOC_OP_SEQ_BIT = 6;
  localparam int OOC_OP_MARGIN_LSB = 4;
  localparam int OOC_OP_FAULT_LSB = 2;
  localparam logic [1:0] OOC_MARGIN_NOMINAL = 2'h0;
  localparam logic [1:0] OOC_MARGIN_LOW = 2'h1;
  localparam logic [1:0] OOC_MARGIN_HIGH = 2'h2;
  localparam logic [1:0] OOC_FAULT_IGNORE = 2'h1;
  localparam logic [1:0] OOC_FAULT_ACT = 2'h2;
  localparam logic [1:0] OOC_OP_UNUSED_BITS = 2'h0;
  localparam int OOC_BAD_OP_COUNT = 8;
  localparam logic [5:0] OOC_BAD_OP [OOC_BAD_OP_COUNT] = '{
    6'h24, 6'h34, 6'h27, 6'h37, 6'h28, 6'h38, 6'h2b, 6'h3b};

  // ==========================================================================
  // Turn-on configuration fields
  localparam int OOC_CFG_ARM_BIT = 4;
  localparam int OOC_CFG_CMD_BIT = 3;
  localparam int OOC_CFG_PIN_BIT = 2;
  localparam int OOC_CFG_POL_BIT = 1;
  localparam int OOC_CFG_PIN_OFF_BIT = 0;
  localparam logic [2:0] OOC_CFG_RESERVED = 3'h0;
  localparam logic [3:0] OOC_MODE_PIN = 4'hb;
  localparam logic [3:0] OOC_MODE_CMD = 4'hd;
  localparam logic [3:0] OOC_MODE_BOTH = 4'hf;

  // ==========================================================================
  // Status flag positions
  localparam int OOC_STATUS_CML_BIT = 1;
  localparam int OOC_CML_INVALID_BIT = 6;

  typedef enum logic [0:0] {
    OOC_LINK_IDLE = 1'b0,
    OOC_LINK_WAIT = 1'b1
  } ooc_link_state_t;

endpackage

// ---- design/ooc_sync.sv ----
`timescale 1ns/100ps
module ooc_sync
  import ooc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second, so a metastable value never fans out.
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      stage1 <= '0;
      q_out <= '0;
    end
    else
    begin
      stage1 <= d_in;
      q_out <= stage1;
    end
  end

endmodule // ooc_sync

// ---- design/ooc_output_control.sv ----
`timescale 1ns/100ps
module ooc_output_control
  import ooc_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic link_clk_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_busy_out,
  output logic cmd_done_out,
  output logic [7:0] cmd_rd_data_out,
  input wire logic enable_pin_in,
  input wire logic fault_clear_in,
  output logic output_on_out,
  output logic off_sequenced_out,
  output logic [1:0] margin_sel_out,
  output logic margin_fault_act_out,
  output logic [7:0] status_byte_out,
  output logic [7:0] status_cml_out,
  output logic nvm_store_out,
  output logic [7:0] nvm_operation_out,
  output logic [7:0] nvm_config_out
);

  // ==========================================================================
  // Link side: capture one request and hold it until the core acknowledges.
  ooc_link_state_t link_state, next_link_state;
  logic req_tgl, next_req_tgl;
  logic req_write, next_req_write;
  logic [7:0] req_code, next_req_code;
  logic [7:0] req_data, next_req_data;
  logic ack_seen, next_ack_seen;
  logic next_cmd_busy, next_cmd_done;
  logic [7:0] next_cmd_rd_data;
  logic ack_tgl_link;
  logic ack_tgl;

  ooc_sync #(.WIDTH(1)) u_ack_sync (
    .clk_in(link_clk_in),
    .sys_rst_in(sys_rst_in),
    .d_in(ack_tgl),
    .q_out(ack_tgl_link)
  );

  // Read data sits in a core register that changes only on the edge that flips the acknowledge toggle,
  // so it is stable by the time the acknowledge toggle arrives.
  logic [7:0] core_rd;

  always_comb
  begin
    next_link_state = link_state;
    next_req_tgl = req_tgl;
    next_req_write = req_write;
    next_req_code = req_code;
    next_req_data = req_data;
    next_ack_seen = ack_seen;
    next_cmd_busy = cmd_busy_out;
    next_cmd_done = 1'b0;
    next_cmd_rd_data = cmd_rd_data_out;
    case (link_state)
      OOC_LINK_IDLE:
      begin
        if (cmd_valid_in)
        begin
          next_req_write = cmd_write_in;
          next_req_code = cmd_code_in;
          next_req_data = cmd_data_in;
          next_req_tgl = ~req_tgl;
          next_cmd_busy = 1'b1;
          next_link_state = OOC_LINK_WAIT;
        end
      end
      OOC_LINK_WAIT:
      begin
        if (ack_tgl_link != ack_seen)
        begin
          next_ack_seen = ack_tgl_link;
          next_cmd_rd_data = core_rd;
          next_cmd_done = 1'b1;
          next_cmd_busy = 1'b0;
          next_link_state = OOC_LINK_IDLE;
        end
      end
      default:
      begin
        next_link_state = OOC_LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      link_state <= OOC_LINK_IDLE;
      req_tgl <= 1'b0;
      req_write <= 1'b0;
      req_code <= OOC_BYTE_ZERO;
      req_data <= OOC_BYTE_ZERO;
      ack_seen <= 1'b0;
      cmd_busy_out <= 1'b0;
      cmd_done_out <= 1'b0;
      cmd_rd_data_out <= OOC_BYTE_ZERO;
    end
    else
    begin
      link_state <= next_link_state;
      req_tgl <= next_req_tgl;
      req_write <= next_req_write;
      req_code <= next_req_code;
      req_data <= next_req_data;
      ack_seen <= next_ack_seen;
      cmd_busy_out <= next_cmd_busy;
      cmd_done_out <= next_cmd_done;
      cmd_rd_data_out <= next_cmd_rd_data;
    end
  end

  // ==========================================================================
  // Core side: synchronise the request toggle and the enable pin.
  logic req_tgl_core;
  logic enable_sync;

  ooc_sync #(.WIDTH(2)) u_core_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .d_in({req_tgl, enable_pin_in}),
    .q_out({req_tgl_core, enable_sync})
  );

  // ==========================================================================
  // Command decode and register file.
  logic [7:0] operation, next_operation;
  logic [7:0] turn_cfg, next_turn_cfg;
  logic req_seen, next_req_seen;
  logic next_ack_tgl;
  logic [7:0] next_core_rd;
  logic next_status_cml, next_cml_invalid;
  logic status_cml, cml_invalid;
  logic next_nvm_store;
  logic [7:0] next_nvm_operation, next_nvm_config;
  logic req_fire, op_write, cfg_write, store_write, bad_op, bad_cfg;
  logic [OOC_BAD_OP_COUNT-1:0] bad_hit;
  logic [3:0] cfg_mode;

  genvar gi;
  generate
    for (gi = 0; gi < OOC_BAD_OP_COUNT; gi++)
    begin : g_bad_op
      assign bad_hit[gi] = (req_data[OOC_OP_ON_BIT:OOC_OP_FAULT_LSB] == OOC_BAD_OP[gi]);
    end
  endgenerate

  assign req_fire = (req_tgl_core != req_seen);
  assign op_write = req_fire && req_write && (req_code == OOC_CMD_OPERATION);
  assign cfg_write = req_fire && req_write && (req_code == OOC_CMD_CONFIG);
  assign store_write = req_fire && req_write && (req_code == OOC_CMD_STORE_ALL);
  assign bad_op = |bad_hit;
  assign cfg_mode = req_data[OOC_CFG_ARM_BIT:OOC_CFG_POL_BIT];
  // Only the four listed turn-on modes pass; reserved bits must be clear.
  assign bad_cfg = (req_data[7:5] != OOC_CFG_RESERVED) ||
                   !((!cfg_mode[3] && cfg_mode[0]) || (cfg_mode == OOC_MODE_PIN) ||
                     (cfg_mode == OOC_MODE_CMD) || (cfg_mode == OOC_MODE_BOTH));

  always_comb
  begin
    next_operation = operation;
    next_turn_cfg = turn_cfg;
    next_req_seen = req_seen;
    next_ack_tgl = ack_tgl;
    next_core_rd = core_rd;
    next_nvm_store = 1'b0;
    next_nvm_operation = nvm_operation_out;
    next_nvm_config = nvm_config_out;
    next_status_cml = status_cml & ~fault_clear_in;
    next_cml_invalid = cml_invalid & ~fault_clear_in;
    if (req_fire)
    begin
      next_req_seen = req_tgl_core;
      next_ack_tgl = ~ack_tgl;
      if (req_write)
      begin
        next_core_rd = OOC_BYTE_ZERO;
      end
      else if (req_code == OOC_CMD_OPERATION)
      begin
        next_core_rd = operation;
      end
      else if (req_code == OOC_CMD_CONFIG)
      begin
        next_core_rd = turn_cfg;
      end
      else
      begin
        next_core_rd = OOC_BYTE_ZERO;
      end
    end
    if (op_write)
    begin
      if (bad_op)
      begin
        next_status_cml = 1'b1;
        next_cml_invalid = 1'b1;
      end
      else
      begin
        next_operation = {req_data[OOC_OP_ON_BIT:OOC_OP_FAULT_LSB], OOC_OP_UNUSED_BITS};
      end
    end
    if (cfg_write)
    begin
      if (bad_cfg)
      begin
        next_status_cml = 1'b1;
        next_cml_invalid = 1'b1;
      end
      else
      begin
        next_turn_cfg = req_data;
      end
    end
    if (store_write)
    begin
      next_nvm_store = 1'b1;
      next_nvm_operation = operation;
      next_nvm_config = turn_cfg;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      operation <= OOC_OPERATION_RESET;
      turn_cfg <= OOC_CONFIG_RESET;
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      core_rd <= OOC_BYTE_ZERO;
      status_cml <= 1'b0;
      cml_invalid <= 1'b0;
      nvm_store_out <= 1'b0;
      nvm_operation_out <= OOC_BYTE_ZERO;
      nvm_config_out <= OOC_BYTE_ZERO;
    end
    else
    begin
      operation <= next_operation;
      turn_cfg <= next_turn_cfg;
      req_seen <= next_req_seen;
      ack_tgl <= next_ack_tgl;
      core_rd <= next_core_rd;
      status_cml <= next_status_cml;
      cml_invalid <= next_cml_invalid;
      nvm_store_out <= next_nvm_store;
      nvm_operation_out <= next_nvm_operation;
      nvm_config_out <= next_nvm_config;
    end
  end

  // ==========================================================================
  // Turn-on decision, recomputed every cycle from the registers and the pin.
  logic cmd_ok, pin_ok, next_on, next_off_seq, next_fault_act;
  logic [1:0] next_margin, op_margin;
  logic [7:0] next_status_byte, next_status_cml_byte;

  assign op_margin = operation[OOC_OP_MARGIN_LSB +: 2];

  always_comb
  begin
    cmd_ok = !turn_cfg[OOC_CFG_CMD_BIT] || operation[OOC_OP_ON_BIT];
    pin_ok = !turn_cfg[OOC_CFG_PIN_BIT] || enable_sync;
    next_on = !turn_cfg[OOC_CFG_ARM_BIT] || (cmd_ok && pin_ok);
    // The operation command wins the shutdown style when it is the cause.
    if (!cmd_ok)
    begin
      next_off_seq = operation[OOC_OP_SEQ_BIT];
    end
    else
    begin
      next_off_seq = !turn_cfg[OOC_CFG_PIN_OFF_BIT];
    end
    next_margin = OOC_MARGIN_NOMINAL;
    if (next_on && operation[OOC_OP_ON_BIT] &&
        ((op_margin == OOC_MARGIN_LOW) || (op_margin == OOC_MARGIN_HIGH)))
    begin
      next_margin = op_margin;
    end
    next_fault_act = (next_margin != OOC_MARGIN_NOMINAL) &&
                     (operation[OOC_OP_FAULT_LSB +: 2] == OOC_FAULT_ACT);
    next_status_byte = OOC_BYTE_ZERO;
    next_status_byte[OOC_STATUS_CML_BIT] = next_status_cml;
    next_status_cml_byte = OOC_BYTE_ZERO;
    next_status_cml_byte[OOC_CML_INVALID_BIT] = next_cml_invalid;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      output_on_out <= 1'b0;
      off_sequenced_out <= 1'b0;
      margin_sel_out <= OOC_MARGIN_NOMINAL;
      margin_fault_act_out <= 1'b0;
      status_byte_out <= OOC_BYTE_ZERO;
      status_cml_out <= OOC_BYTE_ZERO;
    end
    else
    begin
      output_on_out <= next_on;
      off_sequenced_out <= next_off_seq;
      margin_sel_out <= next_margin;
      margin_fault_act_out <= next_fault_act;
      status_byte_out <= next_status_byte;
      status_cml_out <= next_status_cml_byte;
    end
  end

  // ==========================================================================
  // Assertions
  property p_low_bits;
    @(posedge clk_in) disable iff (sys_rst_in)
    operation[1:0] == OOC_OP_UNUSED_BITS;
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("operation low bits not zero");

  property p_bad_op;
    @(posedge clk_in) disable iff (sys_rst_in)
    op_write && bad_op |=> operation == $past(operation) ##1
      status_cml_out[OOC_CML_INVALID_BIT] && status_byte_out[OOC_STATUS_CML_BIT];
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("illegal operation not rejected");

  property p_good_op;
    @(posedge clk_in) disable iff (sys_rst_in)
    op_write && !bad_op |=> operation[7:2] == $past(req_data[7:2]);
  endproperty
  a_good_op: assert property (p_good_op) else $error("legal operation not applied");

  property p_always_on;
    @(posedge clk_in) disable iff (sys_rst_in)
    !turn_cfg[OOC_CFG_ARM_BIT] |=> output_on_out;
  endproperty
  a_always_on: assert property (p_always_on) else $error("output not on in always-on mode");

  property p_cmd_gate;
    @(posedge clk_in) disable iff (sys_rst_in)
    turn_cfg[OOC_CFG_ARM_BIT] && turn_cfg[OOC_CFG_CMD_BIT] && !operation[OOC_OP_ON_BIT]
      |=> !output_on_out && (off_sequenced_out == $past(operation[OOC_OP_SEQ_BIT]));
  endproperty
  a_cmd_gate: assert property (p_cmd_gate) else $error("operation off not obeyed");

  property p_pin_gate;
    @(posedge clk_in) disable iff (sys_rst_in)
    turn_cfg[OOC_CFG_ARM_BIT] && turn_cfg[OOC_CFG_PIN_BIT] && !enable_sync && cmd_ok
      |=> !output_on_out && (off_sequenced_out != $past(turn_cfg[OOC_CFG_PIN_OFF_BIT]));
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin off not obeyed");

  property p_margin;
    @(posedge clk_in) disable iff (sys_rst_in)
    margin_sel_out != OOC_MARGIN_NOMINAL |-> output_on_out &&
      $past(operation[OOC_OP_ON_BIT]) && (margin_sel_out == $past(op_margin));
  endproperty
  a_margin: assert property (p_margin) else $error("margin select wrong");

  property p_fault_act;
    @(posedge clk_in) disable iff (sys_rst_in)
    margin_fault_act_out |-> (margin_sel_out != OOC_MARGIN_NOMINAL) &&
      ($past(operation[OOC_OP_FAULT_LSB +: 2]) == OOC_FAULT_ACT);
  endproperty
  a_fault_act: assert property (p_fault_act) else $error("margin fault policy wrong");

  property p_polarity;
    @(posedge clk_in) disable iff (sys_rst_in)
    turn_cfg[OOC_CFG_POL_BIT];
  endproperty
  a_polarity: assert property (p_polarity) else $error("active-low pin accepted");

  property p_store;
    @(posedge clk_in) disable iff (sys_rst_in)
    store_write |=> nvm_store_out && (nvm_operation_out == $past(operation)) &&
      (nvm_config_out == $past(turn_cfg));
  endproperty
  a_store: assert property (p_store) else $error("store snapshot wrong");

  c_bad_op: cover property (@(posedge clk_in) disable iff (sys_rst_in) op_write && bad_op);
  c_margin_high: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    margin_sel_out == OOC_MARGIN_HIGH);
  c_pin_off: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(output_on_out) && off_sequenced_out);
  c_store: cover property (@(posedge clk_in) disable iff (sys_rst_in) nvm_store_out);

endmodule // ooc_output_control

// ---- verification/ooc_host_model.sv ----
`timescale 1ns/100ps
// ============================================================================
// Host side of the command port: one request at a time, on the link clock.
module ooc_host_model
  import ooc_pkg::*;
(
  input wire logic link_clk_in,
  input wire logic busy_in,
  input wire logic done_in,
  input wire logic [7:0] rd_data_in,
  output logic valid_out,
  output logic write_out,
  output logic [7:0] code_out,
  output logic [7:0] data_out
);
  initial
  begin
    valid_out = 1'b0;
    write_out = 1'b0;
    code_out = 8'h00;
    data_out = 8'h00;
  end

  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data,
                      output logic [7:0] rd, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    rd = 8'h00;
    @(posedge link_clk_in);
    valid_out <= 1'b1;
    write_out <= wr;
    code_out <= code;
    data_out <= data;
    @(posedge link_clk_in);
    // Holding valid until the link returns to idle would be taken as a second request.
    while (busy_in !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge link_clk_in);
    end
    valid_out <= 1'b0;
    code_out <= ~code;
    data_out <= ~data;
    while (done_in !== 1'b1 && n < 32)
    begin
      n++;
      @(posedge link_clk_in);
    end
    rd = rd_data_in;
    ok = (n < 32);
  endtask
endmodule // ooc_host_model

// ---- verification/tb_output_on_off_control.sv ----
`timescale 1ns/100ps
module tb_output_on_off_control;
  import ooc_pkg::*;
  logic clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst_in = 1'b1;
  logic enable_pin = 1'b0;
  logic fault_clear = 1'b0;
  logic cmd_valid, cmd_write, cmd_busy, cmd_done, output_on, off_seq, fault_act, nvm_store;
  logic [7:0] cmd_code, cmd_data, rd_data, status_byte, status_cml, nvm_op, nvm_cfg;
  logic [1:0] margin_sel;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_cycles = 0;
  int n_store = 0;

  always #12.5 clk_in = ~clk_in;
  always #40 link_clk = ~link_clk;

  ooc_output_control dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link_clk_in(link_clk),
    .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_code_in(cmd_code),
    .cmd_data_in(cmd_data), .cmd_busy_out(cmd_busy), .cmd_done_out(cmd_done),
    .cmd_rd_data_out(rd_data), .enable_pin_in(enable_pin), .fault_clear_in(fault_clear),
    .output_on_out(output_on), .off_sequenced_out(off_seq), .margin_sel_out(margin_sel),
    .margin_fault_act_out(fault_act), .status_byte_out(status_byte),
    .status_cml_out(status_cml), .nvm_store_out(nvm_store), .nvm_operation_out(nvm_op),
    .nvm_config_out(nvm_cfg));

  ooc_host_model host (.link_clk_in(link_clk), .busy_in(cmd_busy), .done_in(cmd_done),
    .rd_data_in(rd_data), .valid_out(cmd_valid), .write_out(cmd_write),
    .code_out(cmd_code), .data_out(cmd_data));

  // ==========================================================================
  // Shared checks and bus helpers
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    n_cycles++;
    if (nvm_store === 1'b1) n_store++;
    if (n_cycles == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Core outputs settle before the answer returns; wait a few core cycles more before looking.
  task automatic xfer(input logic w, input logic [7:0] code, input logic [7:0] data,
                      output logic [7:0] rd);
    logic ok;
    host.xfer(w, code, data, rd, ok);
    chk(8'(ok), 8'h01);
    repeat (4) @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    logic [7:0] rd;
    xfer(1'b1, code, data, rd);
  endtask

  task automatic rd_chk(input logic [7:0] code, input logic [7:0] exp);
    logic [7:0] rd;
    xfer(1'b0, code, 8'h00, rd);
    chk(rd, exp);
  endtask

  task automatic set_pin(input logic v);
    @(posedge clk_in);
    enable_pin <= v;
    repeat (5) @(posedge clk_in);
  endtask

  task automatic clear_flags();
    @(posedge clk_in);
    fault_clear <= 1'b1;
    @(posedge clk_in);
    fault_clear <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk(status_byte, 8'h00);
    chk(status_cml, 8'h00);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd_chk(OOC_CMD_CONFIG, 8'h17);
    rd_chk(OOC_CMD_OPERATION, 8'h00);
    chk(8'(output_on), 8'h00);
    set_pin(1'b1);
    chk(8'(output_on), 8'h01);
    set_pin(1'b0);
    chk(8'(output_on), 8'h00);
    chk(8'(off_seq), 8'h00);
  endtask

  task automatic t_op();
    logic [7:0] ops [7] = '{8'h00, 8'h40, 8'h83, 8'h95, 8'h9a, 8'ha6, 8'hab};
    wr(OOC_CMD_CONFIG, 8'h1a);
    for (int i = 0; i < 7; i++)
    begin
      wr(OOC_CMD_OPERATION, ops[i]);
      rd_chk(OOC_CMD_OPERATION, ops[i] & 8'hfc);
      chk(8'(output_on), 8'(ops[i][7]));
      if (ops[i][7] == 1'b0) chk(8'(off_seq), 8'(ops[i][6]));
      else chk(8'(margin_sel), 8'(ops[i][5:4]));
      if (ops[i][7] && ops[i][5:4] != 2'h0) chk(8'(fault_act), 8'(ops[i][3]));
    end
  endtask

  task automatic t_bad();
    logic [5:0] bad [8] = '{6'h24, 6'h34, 6'h27, 6'h37, 6'h28, 6'h38, 6'h2b, 6'h3b};
    for (int i = 0; i < 8; i++)
    begin
      wr(OOC_CMD_OPERATION, {bad[i], 2'h0});
      rd_chk(OOC_CMD_OPERATION, 8'ha8);
      chk(status_byte, 8'h02);
      chk(status_cml, 8'h40);
      clear_flags();
    end
    wr(OOC_CMD_OPERATION, 8'hbc);
    rd_chk(OOC_CMD_OPERATION, 8'hbc);
    chk(status_cml, 8'h00);
    chk(8'(margin_sel), 8'h00);
    chk(8'(fault_act), 8'h00);
  endtask

  task automatic t_cfg();
    wr(OOC_CMD_CONFIG, 8'h02);
    wr(OOC_CMD_OPERATION, 8'h00);
    chk(8'(output_on), 8'h01);
    wr(OOC_CMD_CONFIG, 8'h15);
    rd_chk(OOC_CMD_CONFIG, 8'h02);
    chk(status_cml, 8'h40);
    clear_flags();
    wr(OOC_CMD_CONFIG, 8'h1e);
    wr(OOC_CMD_OPERATION, 8'h80);
    chk(8'(output_on), 8'h00);
    set_pin(1'b1);
    chk(8'(output_on), 8'h01);
    set_pin(1'b0);
    chk(8'(output_on), 8'h00);
    chk(8'(off_seq), 8'h01);
    set_pin(1'b1);
    wr(OOC_CMD_OPERATION, 8'h00);
    chk(8'(output_on), 8'h00);
    chk(8'(off_seq), 8'h00);
  endtask

  task automatic t_store();
    int n0;
    wr(OOC_CMD_OPERATION, 8'h80);
    n0 = n_store;
    wr(OOC_CMD_STORE_ALL, 8'h00);
    chk(8'(n_store - n0), 8'h01);
    chk(nvm_op, 8'h80);
    chk(nvm_cfg, 8'h1e);
    rd_chk(8'h7f, 8'h00);
  endtask

  initial
  begin
    repeat (2) @(posedge link_clk);
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_op();
    t_bad();
    t_cfg();
    t_store();
    finish_test();
  end
endmodule // tb_output_on_off_control
